// ==== hw/logic_cell_consts.svh ====
`ifndef LOGIC_CELL_CONSTS_SVH
`define LOGIC_CELL_CONSTS_SVH
// Register offsets on the plain register port
`define LC_OFS_CTRL_LOW 4'h0
`define LC_OFS_CTRL_HIGH 4'h1
`define LC_OFS_MUX_SEL 4'h2
`define LC_OFS_GATE_EN_LOW 4'h3
`define LC_OFS_GATE_EN_HIGH 4'h4
`define LC_OFS_IRQ_STATUS 4'h5
`define LC_OFS_IRQ_CLEAR 4'h6
`define LC_OFS_IRQ_ENABLE 4'h7
// Field positions in cell_control_low
`define LC_BIT_ENABLE 15
`define LC_BIT_RISE_IRQ 11
`define LC_BIT_FALL_IRQ 10
`define LC_BIT_PIN_DRIVE 7
`define LC_BIT_OUT_STATUS 6
`define LC_BIT_OUT_INVERT 5
// Writable masks; other bits read as zero, except the output status bit in control low
`define LC_MASK_CTRL_LOW 16'h8ca7
`define LC_MASK_CTRL_HIGH 16'h000f
`define LC_MASK_MUX_SEL 16'h7777
`define LC_RESET_VALUE 16'h0000
// Interrupt status bit positions
`define LC_IRQ_RISE 0
`define LC_IRQ_FALL 1
`endif

// ==== hw/logic_cell_pkg.sv ====
package logic_cell_pkg;
  typedef enum logic [2:0] {
    FN_AND_OR,
    FN_OR_XOR,
    FN_AND4,
    FN_SR_LATCH,
    FN_DFF_SR,
    FN_DFF2_R,
    FN_JK_R,
    FN_DLATCH_SR
  } cell_function_t;
  typedef logic [15:0] reg_word_t;
endpackage

// ==== hw/logic_cell_core.sv ====
`timescale 1ns/1ps
module logic_cell_core (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [2:0] i_function,
  input wire logic [3:0] i_gate,
  output logic o_cell
);
  import logic_cell_pkg::*;

  logic state_reg;
  logic state_next;
  logic comb_out;
  logic g1;
  logic g2;
  logic g3;
  logic g4;

  assign g1 = i_gate[0];
  assign g2 = i_gate[1];
  assign g3 = i_gate[2];
  assign g4 = i_gate[3];

  // Latches are modelled as clocked storage: while transparent, the output follows one clock behind
  always_comb begin
    comb_out = 1'b0;
    state_next = state_reg;
    case (cell_function_t'(i_function))
      FN_AND_OR: comb_out = (g1 & g2) | (g3 & g4);
      FN_OR_XOR: comb_out = (g1 | g2) ^ (g3 | g4);
      FN_AND4: comb_out = g1 & g2 & g3 & g4;
      FN_SR_LATCH: begin
        if (g3 | g4) begin
          state_next = 1'b0;
        end else if (g1 | g2) begin
          state_next = 1'b1;
        end
      end
      FN_DFF_SR: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (g4) begin
          state_next = 1'b1;
        end else begin
          state_next = g2;
        end
      end
      FN_DFF2_R: begin
        if (g3) begin
          state_next = 1'b0;
        end else begin
          state_next = g2 & g4;
        end
      end
      FN_JK_R: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (g2 & g4) begin
          state_next = ~state_reg;
        end else if (g2) begin
          state_next = 1'b1;
        end else if (g4) begin
          state_next = 1'b0;
        end
      end
      default: begin
        if (g3) begin
          state_next = 1'b0;
        end else if (g4) begin
          state_next = 1'b1;
        end else if (g1) begin
          state_next = g2;
        end
      end
    endcase
    if (i_function >= 3'h3) begin
      comb_out = state_reg;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_enable) begin
      state_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_cell = i_enable & comb_out;
endmodule

// ==== hw/logic_cell_ctrl.sv ====
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Cell works only while enable bit set
// - Rising and falling edge interrupts, independent
// - Pin driven only while pin enable set
// - Output polarity bit inverts final output
// - Codes 000-010 are AND-OR, OR-XOR, AND4
// - 011 SR latch, 111 transparent latch
// - 100 D flop S/R, 101 two-input D flop
// - 110 JK flip-flop with reset
// - Per-gate polarity bit inverts gate output
// - Four eight-way input multiplexers
// - Each mux gives true and inverted signal
// - Gate ORs its enabled mux outputs
// - Mux two picks comparator, converter, DMA
// - Separate true/inverted enables per gate
// - Pool of exactly thirty-two inputs
`include "logic_cell_consts.svh"
module logic_cell_ctrl #(
  parameter int NUM_SOURCES = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic_cell_pkg::reg_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_SOURCES-1:0] i_sources,
  output logic_cell_pkg::reg_word_t o_rdata,
  output logic o_cell_out,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_irq
);
  import logic_cell_pkg::*;

  // Pool layout: mux n uses sources [8n+7:8n], index equal to select code.
  // Mux 2: 2 comparator one, 4 conversion done, 5 DMA channel 0.
  // Mux 3: 2 comparator two, 6 unit-two compare, 7 unit-three compare.
  if (NUM_SOURCES != 32) begin : g_bad_pool
    $error("NUM_SOURCES must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  reg_word_t ctrl_low_reg;
  reg_word_t ctrl_high_reg;
  reg_word_t mux_sel_reg;
  reg_word_t gate_en_low_reg;
  reg_word_t gate_en_high_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [3:0] mux_out;
  logic [3:0] gate;
  logic [31:0] gate_en;
  logic cell_raw;
  logic final_out;
  logic final_prev_reg;
  logic enable;
  logic rise_evt;
  logic fall_evt;
  logic [1:0] clear_req;

  assign enable = ctrl_low_reg[`LC_BIT_ENABLE];
  assign gate_en = {gate_en_high_reg, gate_en_low_reg};

  function automatic logic pick(input logic [7:0] bank, input logic [2:0] sel);
    pick = bank[sel];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input stage
  always_comb begin
    for (int m = 0; m < 4; m++) begin
      mux_out[m] = pick(i_sources[8*m +: 8], mux_sel_reg[4*m +: 3]);
    end
    for (int g = 0; g < 4; g++) begin
      gate[g] = 1'b0;
      for (int m = 0; m < 4; m++) begin
        // Bit pairs per gate: odd bit true, even bit inverted
        gate[g] = gate[g] | (gate_en[8*g + 2*m + 1] & mux_out[m])
          | (gate_en[8*g + 2*m] & ~mux_out[m]);
      end
      gate[g] = gate[g] ^ ctrl_high_reg[g];
    end
  end

  logic_cell_core u_core (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_enable(enable),
    .i_function(ctrl_low_reg[2:0]),
    .i_gate(gate),
    .o_cell(cell_raw)
  );

  assign final_out = enable & (cell_raw ^ ctrl_low_reg[`LC_BIT_OUT_INVERT]);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, registered
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_cell_out <= 1'b0;
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
      final_prev_reg <= 1'b0;
    end else begin
      o_cell_out <= final_out;
      o_pin_out <= final_out;
      o_pin_oe <= enable & ctrl_low_reg[`LC_BIT_PIN_DRIVE];
      final_prev_reg <= final_out;
    end
  end

  assign rise_evt = enable & ctrl_low_reg[`LC_BIT_RISE_IRQ] & final_out & ~final_prev_reg;
  assign fall_evt = enable & ctrl_low_reg[`LC_BIT_FALL_IRQ] & ~final_out & final_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctrl_low_reg <= `LC_RESET_VALUE;
      ctrl_high_reg <= `LC_RESET_VALUE;
      mux_sel_reg <= `LC_RESET_VALUE;
      gate_en_low_reg <= `LC_RESET_VALUE;
      gate_en_high_reg <= `LC_RESET_VALUE;
      irq_enable_reg <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == `LC_OFS_CTRL_LOW) begin
        ctrl_low_reg <= i_wdata & `LC_MASK_CTRL_LOW;
      end else if (i_addr == `LC_OFS_CTRL_HIGH) begin
        ctrl_high_reg <= i_wdata & `LC_MASK_CTRL_HIGH;
      end else if (i_addr == `LC_OFS_MUX_SEL) begin
        mux_sel_reg <= i_wdata & `LC_MASK_MUX_SEL;
      end else if (i_addr == `LC_OFS_GATE_EN_LOW) begin
        gate_en_low_reg <= i_wdata;
      end else if (i_addr == `LC_OFS_GATE_EN_HIGH) begin
        gate_en_high_reg <= i_wdata;
      end else if (i_addr == `LC_OFS_IRQ_ENABLE) begin
        irq_enable_reg <= i_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event wins over a clear in the same cycle
  assign clear_req = (i_wr && i_addr == `LC_OFS_IRQ_CLEAR) ? i_wdata[1:0] : 2'h0;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg[`LC_IRQ_RISE] <= rise_evt | (irq_status_reg[`LC_IRQ_RISE]
        & ~clear_req[`LC_IRQ_RISE]);
      irq_status_reg[`LC_IRQ_FALL] <= fall_evt | (irq_status_reg[`LC_IRQ_FALL]
        & ~clear_req[`LC_IRQ_FALL]);
    end
  end

  // One cycle behind status, kept registered for a clean level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      if (i_addr == `LC_OFS_CTRL_LOW) begin
        o_rdata <= ctrl_low_reg | (16'(final_out) << `LC_BIT_OUT_STATUS);
      end else if (i_addr == `LC_OFS_CTRL_HIGH) begin
        o_rdata <= ctrl_high_reg;
      end else if (i_addr == `LC_OFS_MUX_SEL) begin
        o_rdata <= mux_sel_reg;
      end else if (i_addr == `LC_OFS_GATE_EN_LOW) begin
        o_rdata <= gate_en_low_reg;
      end else if (i_addr == `LC_OFS_GATE_EN_HIGH) begin
        o_rdata <= gate_en_high_reg;
      end else if (i_addr == `LC_OFS_IRQ_STATUS) begin
        o_rdata <= {14'h0000, irq_status_reg};
      end else if (i_addr == `LC_OFS_IRQ_ENABLE) begin
        o_rdata <= {14'h0000, irq_enable_reg};
      end else begin
        o_rdata <= 16'h0000;
      end
    end else begin
      o_rdata <= 16'h0000;
    end
  end
endmodule

// ==== sim/logic_cell_ctrl_sva.sv ====
`timescale 1ns/1ps
module logic_cell_ctrl_sva #(
  parameter int NUM_SOURCES = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic_cell_pkg::reg_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_SOURCES-1:0] i_sources,
  input wire logic_cell_pkg::reg_word_t o_rdata,
  input wire logic o_cell_out,
  input wire logic o_pin_out,
  input wire logic o_pin_oe,
  input wire logic o_irq
);
  import logic_cell_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  // Config writes need two edges to reach registered outputs
  sequence s_ctl_off; i_wr && i_addr == 4'h0 && !i_wdata[15]; endsequence
  sequence s_drv_off; i_wr && i_addr == 4'h0 && !(i_wdata[15] && i_wdata[7]); endsequence
  sequence s_clr_all; i_wr && i_addr == 4'h6 && i_wdata[1:0] == 2'h3; endsequence
  property p_rd_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap; i_rd && (i_addr > 4'h7 || i_addr == 4'h6) |=> o_rdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pin_eq; o_pin_out == o_cell_out; endproperty
  a_pin_eq: assert property (p_pin_eq) else $error("pin data differs");
  property p_oe_off; s_drv_off |=> ##1 !o_pin_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven");
  property p_dis_zero; s_ctl_off |=> ##1 !o_cell_out; endproperty
  a_dis_zero: assert property (p_dis_zero) else $error("disabled output high");
  property p_clr; s_clr_all |=> ##1 !o_irq; endproperty
  a_clr: assert property (p_clr) else $error("irq after clear");
  // Read data and cell output are loaded from the same level at the same edge
  property p_stat; i_rd && i_addr == 4'h0 |=> o_rdata[6] == o_cell_out; endproperty
  a_stat: assert property (p_stat) else $error("status bit wrong");
  property p_sel_rsv; i_rd && i_addr == 4'h2 |=> (o_rdata & 16'h8888) == 16'h0000; endproperty
  a_sel_rsv: assert property (p_sel_rsv) else $error("select reserved set");
endmodule

// ==== sim/source_pool_model.sv ====
`timescale 1ns/1ps
// Source pool; mux n sees bits 8n+7..8n
module source_pool_model (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_drive,
  output logic [31:0] o_sources
);
  // Registered, as on-chip sources change on the clock
  always_ff @(posedge i_sys_clk) begin
    o_sources <= i_drive;
  end
endmodule

// ==== sim/logic_cell_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module logic_cell_ctrl_tb_top;
  import logic_cell_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr = 4'h0;
  reg_word_t i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] drive = 32'h0;
  logic [31:0] i_sources;
  reg_word_t o_rdata;
  logic o_cell_out;
  logic o_pin_out;
  logic o_pin_oe;
  logic o_irq;
  int mismatches = 0;
  int n_tests = 0;
  // Step: mode, expected output, gates 4..1
  logic [7:0] steps [15] = '{8'h71, 8'h70, 8'h64, 8'h92, 8'h80, 8'h98, 8'h8c, 8'hba,
    8'ha2, 8'hd2, 8'hd0, 8'hc8, 8'hf3, 8'hf0, 8'he1};
  always #2 i_sys_clk = ~i_sys_clk;
  source_pool_model u_pool (.i_sys_clk, .i_drive(drive), .o_sources(i_sources));
  logic_cell_ctrl u_dut (.i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sources,
    .o_rdata, .o_cell_out, .o_pin_out, .o_pin_oe, .o_irq);
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input reg_word_t d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input reg_word_t e, input string n);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(n, e, o_rdata)
  endtask
  // Four edges cover the source register plus the two-edge storage path
  task automatic settle(input logic e, input string n);
    repeat (4) @(posedge i_sys_clk);
    #1;
    `CHK(n, e, o_cell_out)
  endtask
  function automatic logic [31:0] pat(input logic [3:0] g);
    return {7'h0, g[3], 7'h0, g[2], 7'h0, g[1], 7'h0, g[0]};
  endfunction
  function automatic logic fexp(input logic [1:0] f, input logic [3:0] x);
    case (f)
      2'd0: return (x[0] & x[1]) | (x[2] & x[3]);
      2'd1: return (x[0] | x[1]) ^ (x[2] | x[3]);
      default: return &x;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 9; a++) begin
      rd(4'(a), 16'h0000, "reset value");
    end
    wr(4'h0, 16'h7fff);
    rd(4'h0, 16'h0ca7, "control low");
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h000f, "control high");
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'h7777, "mux select");
    wr(4'h6, 16'hffff);
    rd(4'h6, 16'h0000, "clear reg");
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000, "unmapped");
  endtask
  task automatic t_comb();
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0802);
    wr(4'h4, 16'h8020);
    rd(4'h4, 16'h8020, "gate enables");
    for (int k = 0; k < 192; k++) begin
      wr(4'h1, {12'h000, {4{k[4]}}});
      wr(4'h0, {8'h80, 2'b00, k[5], 3'b000, k[7:6]});
      drive <= pat(k[3:0]);
      settle(fexp(k[7:6], k[3:0] ^ {4{k[4]}}) ^ k[5], "comb out");
    end
  endtask
  task automatic t_store();
    wr(4'h1, 16'h0000);
    for (int i = 0; i < 15; i++) begin
      wr(4'h0, {8'h80, 5'b10000, steps[i][7:5]});
      drive <= pat(steps[i][3:0]);
      settle(steps[i][4], "stored out");
      `CHK("pin enable", 1'b1, o_pin_oe)
      `CHK("pin data", steps[i][4], o_pin_out)
    end
  endtask
  task automatic t_irq();
    wr(4'h7, 16'h0003);
    wr(4'h0, 16'h8802);
    drive <= pat(4'hf);
    settle(1'b1, "rise");
    rd(4'h5, 16'h0001, "rise flag");
    `CHK("irq on", 1'b1, o_irq)
    wr(4'h6, 16'h0001);
    drive <= pat(4'h0);
    settle(1'b0, "fall");
    rd(4'h5, 16'h0000, "fall ignored");
    `CHK("irq off", 1'b0, o_irq)
    wr(4'h0, 16'h8402);
    drive <= pat(4'hf);
    settle(1'b1, "rise ignored");
    wr(4'h7, 16'h0000);
    drive <= pat(4'h0);
    settle(1'b0, "fall two");
    rd(4'h5, 16'h0002, "fall flag");
    `CHK("irq masked", 1'b0, o_irq)
    wr(4'h7, 16'h0002);
    rd(4'h5, 16'h0002, "fall held");
    `CHK("irq unmasked", 1'b1, o_irq)
    wr(4'h6, 16'h0003);
    drive <= pat(4'hf);
    settle(1'b1, "high again");
    wr(4'h0, 16'h0482);
    settle(1'b0, "disabled");
    rd(4'h5, 16'h0000, "disable flag");
    `CHK("pin off", 1'b0, o_pin_oe)
  endtask
  task automatic t_mux();
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h8001);
    for (int k = 0; k < 64; k++) begin
      wr(4'h2, 16'(k[2:0]) << (4 * k[4:3]));
      wr(4'h3, 16'h0001 << (2 * k[4:3] + 1 - k[5]));
      drive <= 32'h1 << (8 * k[4:3] + k[2:0]);
      settle(~k[5], "mux pick");
    end
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_regs();
    t_comb();
    t_store();
    t_irq();
    t_mux();
    print_verdict();
  end
  initial begin
    #50000;
    mismatches++;
    print_verdict();
  end
endmodule
bind logic_cell_ctrl logic_cell_ctrl_sva #(.NUM_SOURCES(NUM_SOURCES)) u_sva (.i_sys_clk,
  .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_sources, .o_rdata, .o_cell_out, .o_pin_out,
  .o_pin_oe, .o_irq);
